/* verilog/cps_pkg.sv */
// Constants, states and carriers of the chipset power-up sequencer
package cps_pkg;

	// Clock rate and derived timing
	localparam longint CLK_HZ     = 200_000_000;
	localparam longint REMOTE_HZ  = 4_096_000;
	localparam longint HOLD_MS    = 32;
	localparam longint WAIT_US    = 20;
	localparam longint HOLD_CYC   = (HOLD_MS * CLK_HZ) / 1000;
	localparam int     WAIT_CYC   = int'((WAIT_US * CLK_HZ + 999_999) / 1_000_000);
	localparam int     WAIT_W     = 13;

	// Phase step for two remote-clock edges per period
	localparam int     NCO_W      = 24;
	localparam logic [NCO_W-1:0] NCO_INC =
		NCO_W'(((64'd1 << NCO_W) * 2 * REMOTE_HZ) / CLK_HZ);

	// Reset burst
	localparam logic [3:0] BURST_PULSES = 4'h8;
	localparam int     SEL_EDGES    = 3;

	// Register map
	localparam logic [15:0] STATUS_FIRST_ADDR  = 16'hE502;
	localparam logic [15:0] STATUS_SECOND_ADDR = 16'hE503;
	localparam logic [15:0] MASK_SECOND_ADDR   = 16'hE50B;
	localparam int          RESET_DONE_FLAG_BIT        = 15;
	localparam logic [31:0] STATUS_RST         = 32'h0000_0000;
	localparam logic [31:0] MASK_RST           = 32'h0000_0000;

	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_OFF   = 5'h01,
		ST_HOLD  = 5'h02,
		ST_WAIT  = 5'h04,
		ST_BURST = 5'h08,
		ST_DONE  = 5'h10
	} cps_state_t;

	// Lines towards the remote front-ends
	typedef struct packed {
		logic       remote_clock_out;
		logic       reset_enable;
		logic [3:0] timing_lines;  // neutral, c, b, a
	} cps_remote_t;

	localparam cps_remote_t REMOTE_IDLE = '{1'b1, 1'b1, 4'hF};

	// Register access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [31:0] wdata;
	} cps_reg_req_t;

endpackage

/* verilog/cps_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module cps_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input  wire logic i_clk,
	input  wire logic i_reset,
	input  wire logic i_ce,
	input  wire logic i_pin,
	output logic      o_level
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic lvl_ff;

	// Stage one feeds only stage two
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			s1_ff <= RST_VAL;
			s2_ff <= RST_VAL;
			s3_ff <= RST_VAL;
		end else if (i_ce) begin
			s1_ff <= i_pin;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// Change accepted once stages two and three agree
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			lvl_ff <= RST_VAL;
		end else if (i_ce && (s2_ff == s3_ff)) begin
			lvl_ff <= s3_ff;
		end
	end

	assign o_level = lvl_ff;
endmodule // cps_sync

/* verilog/cps_sequencer.sv */
// Power-up sequencer: hold-off, remote clock, remote reset, reset-done
`timescale 1ns/10ps
// How it works
// - After supply crosses upper threshold, stay idle another 32 ms.
// - Leaving idle, drive a continuous 4.096 MHz remote clock.
// - 20 us after remote clock starts, pull reset enable low.
// - With reset enable low, pulse all four timing lines low eight times.
// - After the burst, return reset enable and timing lines high.
// - When all is running, pull interrupt line two low, set bit 15.
// - Reset-done flag reads 0 during power-up, 1 only once complete.
// - After power-up the two-wire port is the active host port.
// - Right after power-up every register holds its default value; here the second status register has bit 15 set.
// - Supply below about 2 V forces everything inactive.
// - Three falling edges on the select pin switch host port to SPI.
// - Reset-done interrupt ignores every mask bit.
// - Writing 1 to bit 15 clears the flag and releases the line.
module cps_sequencer #(
	parameter longint HOLD_CYCLES = cps_pkg::HOLD_CYC
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_reset,
	input  wire logic                 i_ce,
	input  wire logic                 i_supply_above_upper,
	input  wire logic                 i_supply_below_low,
	input  wire logic                 i_port_select_pin,
	input  wire logic [31:0]          i_status_events,
	input  wire cps_pkg::cps_reg_req_t i_reg_req,
	output logic [31:0]               o_reg_rdata,
	output cps_pkg::cps_remote_t      o_remote,
	output logic                      o_host_irq_line_two_n,
	output logic                      o_spi_selected,
	output logic                      o_ready
);
	localparam int HW = 32;

	initial
		if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (64'd1 << HW))
			$error("HOLD_CYCLES out of range");

	cps_pkg::cps_state_t  state_ff;
	cps_pkg::cps_state_t  nxt_state;
	cps_pkg::cps_remote_t remote_ff;
	logic [HW-1:0]        hold_cnt_ff;
	logic [cps_pkg::WAIT_W-1:0] wait_cnt_ff;
	logic [cps_pkg::NCO_W-1:0]  nco_ff;
	logic                 half_tick;
	logic [3:0]           pulse_cnt_ff;
	logic                 burst_end;
	logic [31:0]          status_second_ff;
	logic [31:0]          status_first_ff;
	logic [31:0]          mask_second_ff;
	logic [31:0]          rdata_ff;
	logic [1:0]           sel_cnt_ff;
	logic                 spi_ff;
	logic                 sel_prev_ff;
	logic                 sup_up, sup_low, sel_lvl;
	logic                 active;
	logic                 wr_second, wr_first;

	// Pin inputs are asynchronous to the device clock
	cps_sync #(.RST_VAL(1'b0)) u_sync_up (
		.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_pin(i_supply_above_upper), .o_level(sup_up));
	cps_sync #(.RST_VAL(1'b1)) u_sync_low (
		.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_pin(i_supply_below_low), .o_level(sup_low));
	cps_sync #(.RST_VAL(1'b1)) u_sync_sel (
		.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_pin(i_port_select_pin), .o_level(sel_lvl));

	// Half-period ticks of the 4.096 MHz remote clock
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			nco_ff <= '0;
		end else if (i_ce) begin
			nco_ff <= nco_ff + cps_pkg::NCO_INC;
		end
	end
	// Carry out; jitter of one clock is the price of a 200 MHz source
	assign half_tick = (nco_ff + cps_pkg::NCO_INC) < nco_ff;
	assign burst_end = half_tick && (pulse_cnt_ff == cps_pkg::BURST_PULSES)
		&& !remote_ff.timing_lines[0];
	assign active = (state_ff != cps_pkg::ST_OFF);

	// Sequencer next state; low supply overrides everything
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cps_pkg::ST_OFF: begin
				if (sup_up)
					nxt_state = cps_pkg::ST_HOLD;
			end
			cps_pkg::ST_HOLD: begin
				if (hold_cnt_ff == HW'(HOLD_CYCLES - 1))
					nxt_state = cps_pkg::ST_WAIT;
			end
			cps_pkg::ST_WAIT: begin
				if (wait_cnt_ff == cps_pkg::WAIT_W'(cps_pkg::WAIT_CYC - 1))
					nxt_state = cps_pkg::ST_BURST;
			end
			cps_pkg::ST_BURST: begin
				if (burst_end)
					nxt_state = cps_pkg::ST_DONE;
			end
			cps_pkg::ST_DONE: nxt_state = cps_pkg::ST_DONE;
			default: nxt_state = cps_pkg::ST_OFF;
		endcase
		if (sup_low)
			nxt_state = cps_pkg::ST_OFF;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			state_ff <= cps_pkg::ST_OFF;
		end else if (i_ce) begin
			state_ff <= nxt_state;
		end
	end

	// Hold-off and settle counters restart on each state entry
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			hold_cnt_ff <= '0;
			wait_cnt_ff <= '0;
		end else if (i_ce) begin
			hold_cnt_ff <= (state_ff == cps_pkg::ST_HOLD)
				? hold_cnt_ff + 1'b1 : '0;
			wait_cnt_ff <= (state_ff == cps_pkg::ST_WAIT)
				? wait_cnt_ff + 1'b1 : '0;
		end
	end

	// Remote lines: clock runs from hold-off exit, burst under reset
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			remote_ff    <= cps_pkg::REMOTE_IDLE;
			pulse_cnt_ff <= '0;
		end else if (i_ce) begin
			if (nxt_state == cps_pkg::ST_OFF ||
			    nxt_state == cps_pkg::ST_HOLD) begin
				remote_ff    <= cps_pkg::REMOTE_IDLE;
				pulse_cnt_ff <= '0;
			end else begin
				if (half_tick)
					remote_ff.remote_clock_out <=
						~remote_ff.remote_clock_out;
				if (nxt_state == cps_pkg::ST_BURST) begin
					remote_ff.reset_enable <= 1'b0;
					if (half_tick) begin
						remote_ff.timing_lines <=
							~remote_ff.timing_lines;
						if (remote_ff.timing_lines[0])
							pulse_cnt_ff <= pulse_cnt_ff + 1'b1;
					end
				end else begin
					remote_ff.reset_enable <= 1'b1;
					remote_ff.timing_lines <= 4'hF;
				end
			end
		end
	end

	assign wr_second = i_reg_req.wr &&
		(i_reg_req.addr == cps_pkg::STATUS_SECOND_ADDR);
	assign wr_first = i_reg_req.wr &&
		(i_reg_req.addr == cps_pkg::STATUS_FIRST_ADDR);

	// Sticky status; set beats a same-cycle write-one clear
	// Cleared on the edge that enters OFF, so no stale flag survives
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			status_second_ff <= cps_pkg::STATUS_RST;
			status_first_ff  <= cps_pkg::STATUS_RST;
		end else if (i_ce) begin
			if (!active || nxt_state == cps_pkg::ST_OFF) begin
				status_second_ff <= cps_pkg::STATUS_RST;
				status_first_ff  <= cps_pkg::STATUS_RST;
			end else begin
				status_second_ff <= (status_second_ff &
					~(wr_second ? i_reg_req.wdata : 32'h0000_0000))
					| ((state_ff == cps_pkg::ST_DONE) ? 32'h0000_0000 :
					{16'h0000, burst_end, 15'h0000})
					| ((state_ff == cps_pkg::ST_DONE) ?
					{i_status_events[31:16], 1'b0,
					 i_status_events[14:0]} : 32'h0000_0000);
				status_first_ff <= (status_first_ff &
					~(wr_first ? i_reg_req.wdata : 32'h0000_0000))
					| ((state_ff == cps_pkg::ST_DONE) ?
					i_status_events : 32'h0000_0000);
			end
		end
	end

	// Mask; bit 15 has no function and stays zero
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			mask_second_ff <= cps_pkg::MASK_RST;
		end else if (i_ce) begin
			if (!active || nxt_state == cps_pkg::ST_OFF)
				mask_second_ff <= cps_pkg::MASK_RST;
			else if (i_reg_req.wr &&
				 i_reg_req.addr == cps_pkg::MASK_SECOND_ADDR)
				mask_second_ff <= i_reg_req.wdata &
					~(32'h1 << cps_pkg::RESET_DONE_FLAG_BIT);
		end
	end

	// Read data held in flip-flops; unmapped addresses read zero
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_ff <= 32'h0000_0000;
		end else if (i_ce && i_reg_req.rd) begin
			case (i_reg_req.addr)
				cps_pkg::STATUS_SECOND_ADDR: rdata_ff <= status_second_ff;
				cps_pkg::STATUS_FIRST_ADDR:  rdata_ff <= status_first_ff;
				cps_pkg::MASK_SECOND_ADDR:   rdata_ff <= mask_second_ff;
				default:                     rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Port selection: three select falling edges after power-up
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sel_prev_ff <= 1'b1;
			sel_cnt_ff  <= '0;
			spi_ff      <= 1'b0;
		end else if (i_ce) begin
			sel_prev_ff <= sel_lvl;
			if (state_ff != cps_pkg::ST_DONE) begin
				sel_cnt_ff <= '0;
				spi_ff     <= 1'b0;
			end else if (sel_prev_ff && !sel_lvl && !spi_ff) begin
				if (sel_cnt_ff == 2'(cps_pkg::SEL_EDGES - 1))
					spi_ff <= 1'b1;
				else
					sel_cnt_ff <= sel_cnt_ff + 1'b1;
			end
		end
	end

	// Reset-done bypasses the mask
	assign o_host_irq_line_two_n = ~(status_second_ff[cps_pkg::RESET_DONE_FLAG_BIT]
		| (|(status_second_ff & mask_second_ff)));
	assign o_remote       = remote_ff;
	assign o_reg_rdata    = rdata_ff;
	assign o_spi_selected = spi_ff;
	assign o_ready        = (state_ff == cps_pkg::ST_DONE);

	a_hold_quiet: assert property (@(posedge i_clk) disable iff (i_reset)
		state_ff == cps_pkg::ST_HOLD |-> remote_ff == cps_pkg::REMOTE_IDLE)
		else $error("remote lines active during hold-off");
	a_hold_exit: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_ff == cps_pkg::ST_WAIT) |->
		$past(hold_cnt_ff) == HW'(HOLD_CYCLES - 1))
		else $error("hold-off length wrong");
	a_clk_runs: assert property (@(posedge i_clk) disable iff (i_reset)
		i_ce && half_tick && state_ff == cps_pkg::ST_WAIT &&
		nxt_state == cps_pkg::ST_WAIT |=> $changed(remote_ff.remote_clock_out))
		else $error("remote clock not toggling");
	a_wait_len: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_ff == cps_pkg::ST_BURST) |->
		$past(wait_cnt_ff) == cps_pkg::WAIT_W'(cps_pkg::WAIT_CYC - 1)
		&& !remote_ff.reset_enable)
		else $error("reset enable timing wrong");
	a_burst_count: assert property (@(posedge i_clk) disable iff (i_reset)
		$fell(remote_ff.timing_lines[0]) |->
		!remote_ff.reset_enable && pulse_cnt_ff <= cps_pkg::BURST_PULSES)
		else $error("timing line pulse outside burst");
	a_burst_end: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_ff == cps_pkg::ST_DONE) |->
		$past(pulse_cnt_ff) == cps_pkg::BURST_PULSES &&
		remote_ff.reset_enable && remote_ff.timing_lines == 4'hF)
		else $error("burst did not end cleanly");
	a_done_flag: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_ff == cps_pkg::ST_DONE) |->
		status_second_ff[cps_pkg::RESET_DONE_FLAG_BIT] && !o_host_irq_line_two_n)
		else $error("reset-done not raised");
	a_flag_early: assert property (@(posedge i_clk) disable iff (i_reset)
		state_ff != cps_pkg::ST_DONE |->
		!status_second_ff[cps_pkg::RESET_DONE_FLAG_BIT])
		else $error("reset-done set before completion");
	a_irq_unmask: assert property (@(posedge i_clk) disable iff (i_reset)
		status_second_ff[cps_pkg::RESET_DONE_FLAG_BIT] |-> !o_host_irq_line_two_n)
		else $error("reset-done interrupt masked");
	a_flag_clear: assert property (@(posedge i_clk) disable iff (i_reset)
		i_ce && wr_second && i_reg_req.wdata[cps_pkg::RESET_DONE_FLAG_BIT] &&
		state_ff == cps_pkg::ST_DONE |=>
		!status_second_ff[cps_pkg::RESET_DONE_FLAG_BIT])
		else $error("reset-done not cleared");
	a_port_default: assert property (@(posedge i_clk) disable iff (i_reset)
		$rose(state_ff == cps_pkg::ST_DONE) |-> !spi_ff)
		else $error("SPI active at power-up");
	a_low_supply: assert property (@(posedge i_clk) disable iff (i_reset)
		i_ce && sup_low |=> state_ff == cps_pkg::ST_OFF &&
		remote_ff == cps_pkg::REMOTE_IDLE)
		else $error("not inactive on low supply");
endmodule // cps_sequencer

/* sim/cps_remote_model.sv */
// Behavioural model of the remote front-ends watching their control lines
`timescale 1ns/10ps
module cps_remote_model (
	input  wire cps_pkg::cps_remote_t i_remote,
	input  wire logic                 i_clear,
	output int                        o_falls,
	output realtime                   o_clk_start,
	output realtime                   o_rst_start,
	output realtime                   o_span16,
	output logic                      o_split
);
	int      rises;
	realtime t_first;

	// Forget the previous power-up; an idle clock sits high meanwhile
	always @(posedge i_clear or negedge i_clear) begin
		o_falls = 0;
		o_clk_start = 0.0;
		o_rst_start = 0.0;
		o_span16 = 0.0;
		o_split = 1'b0;
		rises = 0;
	end

	// First clock edge marks the end of the idle state
	always @(i_remote.remote_clock_out) begin
		if (o_clk_start == 0.0)
			o_clk_start = $realtime;
	end

	// Sixteen periods averaged, since each edge may jitter one cycle
	always @(posedge i_remote.remote_clock_out) begin
		rises++;
		if (rises == 1)
			t_first = $realtime;
		if (rises == 17)
			o_span16 = $realtime - t_first;
	end

	// Front-end reset starts when reset enable drops
	always @(negedge i_remote.reset_enable) begin
		o_rst_start = $realtime;
	end

	// Only falls seen under reset enable reset the front-ends
	always @(negedge i_remote.timing_lines[0]) begin
		if (!i_remote.reset_enable)
			o_falls++;
	end

	// All four lines must move together
	always @(i_remote.timing_lines) begin
		#0.1;
		if (i_remote.timing_lines != 4'h0 && i_remote.timing_lines != 4'hF)
			o_split = 1'b1;
	end
endmodule // cps_remote_model

/* sim/tb.sv */
// Self-checking bench of the power-up sequencer with a remote model
`timescale 1ns/10ps
module tb;
	localparam longint HOLD = 50;
	logic                  i_clk, i_reset, i_ce, up, low, sel, clr;
	logic [31:0]           evt, rdata, rd_val;
	cps_pkg::cps_reg_req_t req;
	cps_pkg::cps_remote_t  remote;
	logic                  irq_n, spi, ready, split;
	int                    error_cnt, check_count, falls;
	realtime               t_up, t_clk, t_rst, span;

	cps_sequencer #(.HOLD_CYCLES(HOLD)) u_cps_sequencer (
		.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_supply_above_upper(up), .i_supply_below_low(low),
		.i_port_select_pin(sel), .i_status_events(evt), .i_reg_req(req),
		.o_reg_rdata(rdata), .o_remote(remote),
		.o_host_irq_line_two_n(irq_n), .o_spi_selected(spi), .o_ready(ready)
	);

	cps_remote_model u_cps_remote_model (
		.i_remote(remote), .i_clear(clr), .o_falls(falls),
		.o_clk_start(t_clk), .o_rst_start(t_rst), .o_span16(span),
		.o_split(split)
	);

	// 200 MHz device clock
	initial i_clk = 1'b0;
	always #2.5 i_clk = ~i_clk;

	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask

	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Idle cycle after each access keeps strobes from re-driving at once
	task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
		req = '{1'b1, 1'b0, a, d};
		tick(1);
		req = '0;
		tick(1);
	endtask

	task automatic reg_rd(input logic [15:0] a);
		req = '{1'b0, 1'b1, a, 32'h0};
		tick(1);
		req = '0;
		rd_val = rdata;
		tick(1);
	endtask

	// Select pin toggles at the 64 ns link rate, unrelated to the clock
	task automatic sel_pulses(input int n);
		repeat (n) begin
			sel = 1'b0;
			#32;
			sel = 1'b1;
			#32;
		end
		tick(1);
	endtask

	// Host waits for the interrupt before touching anything
	task automatic power_up();
		low = 1'b0;
		up = 1'b1;
		t_up = $realtime;
		for (int n = 0; n < 30000 && irq_n !== 1'b0; n++) tick(1);
		check("ready", ready, 1'b1);
		check("irq_n", irq_n, 1'b0);
		check("hold", 32'(t_clk - t_up >= HOLD * 5.0), 1);
		check("hold_max", 32'(t_clk - t_up <= HOLD * 5.0 + 200.0), 1);
		check("rst_dly", 32'(t_rst - t_clk >= 19850.0), 1);
		check("rst_max", 32'(t_rst - t_clk <= 20010.0), 1);
		check("span", 32'(span >= 3900.0 && span <= 3913.0), 1);
		check("falls", falls, 8);
		check("split", split, 1'b0);
		// Remote clock keeps running, so only reset lines are compared
		check("remote", {remote.reset_enable, remote.timing_lines}, 5'h1F);
		check("spi", spi, 1'b0);
		reg_rd(cps_pkg::STATUS_SECOND_ADDR);
		check("status", rd_val, 32'h0000_8000);
		reg_rd(cps_pkg::MASK_SECOND_ADDR);
		check("mask_dflt", rd_val, cps_pkg::MASK_RST);
	endtask

	task automatic close_out();
		if (error_cnt == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		i_reset = 1'b1;
		i_ce = 1'b1;
		up = 1'b0;
		low = 1'b1;
		sel = 1'b1;
		clr = 1'b0;
		evt = 32'h0;
		req = '0;
		error_cnt = 0;
		check_count = 0;
		tick(20);
		i_reset = 1'b0;
		tick(2);
		check("off_lines", 32'(remote), 32'(cps_pkg::REMOTE_IDLE));
		// Clear the model after reset so time-zero edges are not counted
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		fork
			power_up();
			begin
				tick(25);
				reg_rd(cps_pkg::STATUS_SECOND_ADDR);
				check("flag_hold", rd_val[15], 1'b0);
				sel_pulses(3);
				for (int n = 0; n < 6000 && remote.reset_enable; n++) tick(1);
				reg_rd(cps_pkg::STATUS_SECOND_ADDR);
				check("flag_burst", rd_val[15], 1'b0);
			end
		join
		reg_wr(cps_pkg::MASK_SECOND_ADDR, 32'hFFFF_FFFF);
		reg_rd(cps_pkg::MASK_SECOND_ADDR);
		check("mask", rd_val, 32'hFFFF_7FFF);
		check("irq_kept", irq_n, 1'b0);
		reg_wr(cps_pkg::STATUS_SECOND_ADDR, 32'h0000_8000);
		check("irq_free", irq_n, 1'b1);
		reg_rd(cps_pkg::STATUS_SECOND_ADDR);
		check("flag_clr", rd_val, 32'h0);
		evt = 32'h0000_0008;
		tick(1);
		evt = 32'h0;
		tick(1);
		check("irq_evt", irq_n, 1'b0);
		reg_rd(cps_pkg::STATUS_FIRST_ADDR);
		check("first", rd_val, 32'h0000_0008);
		reg_rd(16'hE504);
		check("unmapped", rd_val, 32'h0);
		reg_wr(cps_pkg::STATUS_SECOND_ADDR, 32'hFFFF_FFFF);
		reg_wr(cps_pkg::STATUS_FIRST_ADDR, 32'hFFFF_FFFF);
		check("irq_all", irq_n, 1'b1);
		reg_rd(cps_pkg::STATUS_FIRST_ADDR);
		check("first_clr", rd_val, 32'h0);
		// Edges before power-up completed were ignored, so two more are not enough
		sel_pulses(2);
		tick(10);
		check("spi_two", spi, 1'b0);
		sel_pulses(1);
		tick(10);
		check("spi_three", spi, 1'b1);
		low = 1'b1;
		tick(8);
		check("down_ready", ready, 1'b0);
		check("down_lines", 32'(remote), 32'(cps_pkg::REMOTE_IDLE));
		check("down_spi", spi, 1'b0);
		check("down_irq", irq_n, 1'b1);
		clr = 1'b1;
		tick(1);
		clr = 1'b0;
		power_up();
		close_out();
	end

	// Two power-ups take about 45 us; allow over six times that
	initial begin
		#300000;
		error_cnt++;
		close_out();
	end
endmodule // tb
